// ---- verilog/sts_pkg.sv ----
// Package of constants for the slope trigger and external start/stop block.
`default_nettype none
package sts_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int MIN_PULSE_NS = 200;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCKOUT_MS = 100;
  localparam int LOCKOUT_CYC = LOCKOUT_MS * 1000 * CLK_MHZ;
  localparam int RESP_DELAY_CYC = 4;
  // ==========================================================================
  // Slope trigger
  localparam int GAP_MAX = 1023;
  localparam int GAP_W = 10;
  localparam int SAMPLE_W = 16;
  // ==========================================================================
  // Register map (AHB-Lite byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GAP = 8'h04;
  localparam logic [7:0] OFS_THRESH = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_DIFF = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  // Control bits.
  localparam int CTRL_TRIG_EN = 0;
  localparam int CTRL_FALLING = 1;
  localparam int CTRL_EXT_EN = 2;
  localparam int CTRL_INV_END = 3;
  localparam int CTRL_INV_BEGIN = 4;
  // Status bits.
  localparam int ST_TRIG = 0;
  localparam int ST_BEGIN = 1;
  localparam int ST_END = 2;
  localparam int NUM_EV = 3;
endpackage
`default_nettype wire

// ---- verilog/sts_slope_startstop.sv ----
// Slope trigger and external start/stop event unit with AHB-Lite registers.
`default_nettype none
module sts_slope_startstop #(
  parameter int SAMPLE_W = sts_pkg::SAMPLE_W,
  parameter int LOCKOUT_CYC = sts_pkg::LOCKOUT_CYC
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sampleData,
  input  wire logic                run_begin_input_a,
  input  wire logic                run_begin_input_b,
  input  wire logic                run_end_input_a,
  input  wire logic                run_end_input_b,
  output logic                     slopeTrigger,
  output logic                     acqRunning,
  output logic                     irq
);
  // ==========================================================================
  // Bus slave. The AHB names stay as published; they drive clk_sys and reset_n.
  logic clk_sys;
  logic reset_n;
  assign clk_sys = hclk;
  assign reset_n = hresetn;

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [sts_pkg::GAP_W-1:0] gap_r, gap_nxt;
  logic signed [SAMPLE_W:0] thresh_r, thresh_nxt;
  logic [sts_pkg::NUM_EV-1:0] status_r, status_nxt, mask_r, mask_nxt;
  logic wrPend_r, wrPend_nxt;
  logic [7:0] wrAddr_r, wrAddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic irq_r, irq_nxt;
  logic [sts_pkg::NUM_EV-1:0] evPulse;
  logic signed [SAMPLE_W:0] diff_r;
  logic running_r;
  logic [1:0] pendFlags;
  logic addrPhase;

  // Address phase is taken when selected, NONSEQ/SEQ and the bus is ready.
  assign addrPhase = hsel && htrans[1] && hready;

  // Register writes land in the data phase; reads answer in zero wait states.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    gap_nxt = gap_r;
    thresh_nxt = thresh_r;
    mask_nxt = mask_r;
    wrPend_nxt = addrPhase && hwrite;
    wrAddr_nxt = addrPhase ? haddr[7:0] : wrAddr_r;
    hrdata_nxt = hrdata_r;
    status_nxt = status_r;
    if (wrPend_r)
    begin
      unique case (wrAddr_r)
        sts_pkg::OFS_CTRL:   ctrl_nxt = {27'h0000000, hwdata[4:0]};
        sts_pkg::OFS_GAP:    gap_nxt = hwdata[sts_pkg::GAP_W-1:0];
        sts_pkg::OFS_THRESH: thresh_nxt = hwdata[SAMPLE_W:0];
        sts_pkg::OFS_STATUS: status_nxt = status_r & ~hwdata[sts_pkg::NUM_EV-1:0];
        sts_pkg::OFS_MASK:   mask_nxt = hwdata[sts_pkg::NUM_EV-1:0];
        default:             ctrl_nxt = ctrl_r;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle.
    status_nxt = status_nxt | evPulse;
    if (addrPhase && !hwrite)
    begin
      unique case (haddr[7:0])
        sts_pkg::OFS_CTRL:   hrdata_nxt = ctrl_r;
        sts_pkg::OFS_GAP:    hrdata_nxt = {22'h000000, gap_r};
        sts_pkg::OFS_THRESH: hrdata_nxt = 32'(thresh_r);
        sts_pkg::OFS_STATUS: hrdata_nxt = {29'h00000000, status_r};
        sts_pkg::OFS_MASK:   hrdata_nxt = {29'h00000000, mask_r};
        sts_pkg::OFS_DIFF:   hrdata_nxt = 32'(diff_r);
        sts_pkg::OFS_STATE:  hrdata_nxt = {29'h00000000, pendFlags, running_r};
        default:             hrdata_nxt = 32'h00000000;
      endcase
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // Registers of the bus slave.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= 32'h00000000;
      gap_r <= '0;
      thresh_r <= '0;
      status_r <= '0;
      mask_r <= '0;
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      irq_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      gap_r <= gap_nxt;
      thresh_r <= thresh_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      hrdata_r <= hrdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_r;

  // ==========================================================================
  // Slope trigger: history line of up to 1023 samples plus the newest.
  localparam int HIST = sts_pkg::GAP_MAX + 1;
  logic [SAMPLE_W-1:0] hist_r [HIST];
  logic [sts_pkg::GAP_W-1:0] wp_r, wp_nxt;
  logic signed [SAMPLE_W:0] diff_nxt;
  logic hitPrev_r, hitPrev_nxt, hit, trig_r, trig_nxt, diffValid_r;
  logic [sts_pkg::GAP_W-1:0] rdIdx;

  // Old sample sits gap entries behind the write pointer.
  assign rdIdx = wp_r - gap_r;

  // Difference, threshold test and edge on the difference.
  always_comb
  begin
    wp_nxt = wp_r;
    diff_nxt = diff_r;
    hitPrev_nxt = hitPrev_r;
    trig_nxt = 1'b0;
    hit = 1'b0;
    if (sampleValid)
    begin
      wp_nxt = wp_r + 10'h001;
      diff_nxt = $signed({1'b0, sampleData}) - $signed({1'b0, hist_r[rdIdx]});
      if (ctrl_r[sts_pkg::CTRL_FALLING])
        hit = diff_nxt <= -thresh_r;
      else
        hit = diff_nxt >= thresh_r;
      hitPrev_nxt = hit;
      trig_nxt = ctrl_r[sts_pkg::CTRL_TRIG_EN] && diffValid_r && hit && !hitPrev_r;
    end
  end

  // History storage is written at the pointer; the newest sample is compared first.
  always_ff @(posedge clk_sys)
  begin
    if (sampleValid)
      hist_r[wp_r] <= sampleData;
  end

  // Slope trigger state.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_r <= '0;
      diff_r <= '0;
      hitPrev_r <= 1'b1;
      trig_r <= 1'b0;
      diffValid_r <= 1'b0;
    end
    else
    begin
      wp_r <= wp_nxt;
      diff_r <= diff_nxt;
      hitPrev_r <= hitPrev_nxt;
      trig_r <= trig_nxt;
      if (sampleValid && wp_r == 10'h3FF)
        diffValid_r <= 1'b1;
    end
  end

  assign slopeTrigger = trig_r;

  // ==========================================================================
  // External start/stop: per-input sync, width filter and edge detect.
  logic [3:0] pinIn;
  logic [3:0] sync1_r, sync2_r;
  logic [3:0] inv;
  logic [3:0] edgeHit;
  assign pinIn = {run_end_input_b, run_end_input_a, run_begin_input_b, run_begin_input_a};
  assign inv = {{2{ctrl_r[sts_pkg::CTRL_INV_END]}}, {2{ctrl_r[sts_pkg::CTRL_INV_BEGIN]}}};

  // Two-stage synchroniser on every pin.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end
    else
    begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : gFilt
      logic [7:0] cnt_r, cnt_nxt;
      logic lvl;
      logic fired_r, fired_nxt;
      // Active level after invert; an edge is accepted once it lasts 200 ns.
      assign lvl = sync2_r[gi] ^ inv[gi];
      always_comb
      begin
        cnt_nxt = cnt_r;
        fired_nxt = fired_r;
        edgeHit[gi] = 1'b0;
        if (!lvl)
        begin
          cnt_nxt = 8'h00;
          fired_nxt = 1'b0;
        end
        else if (!fired_r)
        begin
          if (cnt_r == 8'(sts_pkg::MIN_PULSE_CYC - 1))
          begin
            edgeHit[gi] = 1'b1;
            fired_nxt = 1'b1;
          end
          else
            cnt_nxt = cnt_r + 8'h01;
        end
      end
      // Width counter registers; a start from reset needs a low level first.
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          cnt_r <= 8'h00;
          fired_r <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          fired_r <= fired_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Lockout, pending events and delayed run control.
  logic [31:0] lock_r [2];
  logic [31:0] lock_nxt [2];
  logic [1:0] pend_r, pend_nxt;
  logic [3:0] resp_r, resp_nxt;
  logic run_nxt, beginAcc, endAcc;
  assign pendFlags = pend_r;

  always_comb
  begin
    beginAcc = ctrl_r[sts_pkg::CTRL_EXT_EN] && (edgeHit[0] || edgeHit[1]) && lock_r[0] == 0;
    endAcc = ctrl_r[sts_pkg::CTRL_EXT_EN] && (edgeHit[2] || edgeHit[3]) && lock_r[1] == 0;
    lock_nxt[0] = (lock_r[0] != 0) ? lock_r[0] - 32'h00000001 : lock_r[0];
    lock_nxt[1] = (lock_r[1] != 0) ? lock_r[1] - 32'h00000001 : lock_r[1];
    if (beginAcc)
      lock_nxt[0] = 32'(LOCKOUT_CYC - 1);
    if (endAcc)
      lock_nxt[1] = 32'(LOCKOUT_CYC - 1);
    pend_nxt = pend_r | {endAcc, beginAcc};
    resp_nxt = resp_r;
    run_nxt = running_r;
    evPulse = {endAcc, beginAcc, trig_r};
    // Pending start is served first, then a pending stop, each after a delay.
    if (pend_r != 2'b00)
    begin
      if (resp_r == 4'(sts_pkg::RESP_DELAY_CYC - 1))
      begin
        resp_nxt = 4'h0;
        if (pend_r[0])
        begin
          run_nxt = 1'b1;
          pend_nxt[0] = beginAcc;
        end
        else
        begin
          run_nxt = 1'b0;
          pend_nxt[1] = endAcc;
        end
      end
      else
        resp_nxt = resp_r + 4'h1;
    end
  end

  // Run control registers.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_r[0] <= 32'h00000000;
      lock_r[1] <= 32'h00000000;
      pend_r <= 2'b00;
      resp_r <= 4'h0;
      running_r <= 1'b0;
    end
    else
    begin
      lock_r[0] <= lock_nxt[0];
      lock_r[1] <= lock_nxt[1];
      pend_r <= pend_nxt;
      resp_r <= resp_nxt;
      running_r <= run_nxt;
    end
  end

  assign acqRunning = running_r;
endmodule
`default_nettype wire

// ---- testbench/sts_slope_startstop_assertions.sv ----
// Concurrent checks on the ports of the slope trigger and start/stop block.
`default_nettype none
module sts_slope_startstop_assertions #(
  parameter int LOCKOUT_CYC = 400
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sampleValid,
  input wire logic        slopeTrigger,
  input wire logic        acqRunning
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Helper counters
  logic        runPrev_r;
  int          lockCnt_r;
  int          lockCnt_nxt;
  logic [10:0] seenCnt_r;
  logic [10:0] seenCnt_nxt;
  logic        rdTaken;
  // Reload the lockout count on a start and count samples up to a full history.
  always_comb
  begin
    lockCnt_nxt = (acqRunning && !runPrev_r) ? LOCKOUT_CYC - 8 : (lockCnt_r > 0 ? lockCnt_r - 1 : 0);
    seenCnt_nxt = (sampleValid && seenCnt_r != 11'h400) ? seenCnt_r + 11'h1 : seenCnt_r;
  end
  // Register the helper state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      runPrev_r <= 1'b0;
      lockCnt_r <= 0;
      seenCnt_r <= 11'h0;
    end
    else
    begin
      runPrev_r <= acqRunning;
      lockCnt_r <= lockCnt_nxt;
      seenCnt_r <= seenCnt_nxt;
    end
  end
  assign rdTaken = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ready_const_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not OKAY");
  unmapped_read_a: assert property (rdTaken && haddr[7:0] > 8'h18 |=> hrdata == 32'h0) else $error("unmapped read");
  rdata_hold_a: assert property (!$past(rdTaken) |-> $stable(hrdata)) else $error("hrdata moved");
  trig_after_sample_a: assert property (slopeTrigger |-> $past(sampleValid)) else $error("late trigger");
  trig_single_a: assert property (slopeTrigger |=> !slopeTrigger) else $error("long trigger");
  trig_history_a: assert property (slopeTrigger |-> seenCnt_r == 11'h400) else $error("early trigger");
  start_lockout_a: assert property (acqRunning && !runPrev_r |-> lockCnt_r == 0) else $error("start in lockout");
endmodule
bind sts_slope_startstop sts_slope_startstop_assertions #(.LOCKOUT_CYC(LOCKOUT_CYC)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sampleValid(sampleValid),
  .slopeTrigger(slopeTrigger), .acqRunning(acqRunning));
`default_nettype wire

// ---- testbench/sts_event_source.sv ----
// Model of the external equipment driving the start and stop event pins.
`default_nettype none
module sts_event_source (
  input  wire logic clk,
  input  wire logic idleLevel,
  output logic      beginA,
  output logic      beginB,
  output logic      endA,
  output logic      endB
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Pin drivers
  logic [3:0] act = 4'h0;
  // Each pin rests at its idle level and is inverted while its pulse lasts.
  assign beginA = idleLevel ^ act[0];
  assign beginB = idleLevel ^ act[1];
  assign endA = idleLevel ^ act[2];
  assign endB = idleLevel ^ act[3];
  // Drive one pulse of the given width in clock cycles on one pin.
  task automatic pulse(input int pin, input int width);
    act[pin] <= 1'b1;
    repeat (width) @(posedge clk);
    act[pin] <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_slope_trigger_and_ext_start_stop.sv ----
// Self-checking bench for the slope trigger and external start/stop block.
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module test_slope_trigger_and_ext_start_stop;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 400;
  logic        clk_sys = 1'b0;
  logic        reset_n, hsel, hwrite, hreadyout, sampleValid, idleLevel;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [15:0] sampleData, v;
  wire logic   slopeTrigger, acqRunning, irq, pinBa, pinBb, pinEa, pinEb;
  int          n_mismatch, n_checks, cycles, nSamp, nTrig, trigAt, gap, slp;
  sts_slope_startstop #(.LOCKOUT_CYC(LOCK)) i_dut (
    .hclk(clk_sys), .hresetn(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .sampleValid(sampleValid), .sampleData(sampleData), .run_begin_input_a(pinBa), .run_begin_input_b(pinBb),
    .run_end_input_a(pinEa), .run_end_input_b(pinEb), .slopeTrigger(slopeTrigger), .acqRunning(acqRunning),
    .irq(irq));
  sts_event_source i_src (.clk(clk_sys), .idleLevel(idleLevel), .beginA(pinBa), .beginB(pinBb),
    .endA(pinEa), .endB(pinEb));
  // ==========================================
  // Clock, timeout and tasks
  initial forever #2 clk_sys = ~clk_sys;
  // Cut a hang short after a generous number of cycles.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  // Threshold that the ramp first meets on its gap-th sample.
  function automatic int thresh_for(int g, int s);
    return s * (g - 1) + 1;
  endfunction
  // One single-word bus transfer; read data is taken at the data-phase edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask
  // Present one sample and note whether it fired the trigger; the pulse stands for the one cycle after the sample.
  task automatic put_sample(input logic [15:0] s);
    sampleValid <= 1'b1;
    sampleData <= s;
    @(posedge clk_sys);
    sampleValid <= 1'b0;
    #1;
    if (slopeTrigger === 1'b1)
    begin
      nTrig++;
      trigAt = nSamp;
    end
    nSamp++;
    @(posedge clk_sys);
  endtask
  // Wait a bounded time for the run state to reach a level.
  task automatic wait_run(input logic ex, input int lim);
    for (int i = 0; i < lim && acqRunning !== ex; i++) @(posedge clk_sys);
  endtask
  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence: registers, slope trigger with interrupt, then start/stop events.
  initial
  begin
    {reset_n, hsel, hwrite, sampleValid, idleLevel, htrans} = 7'h0;
    {haddr, hwdata, sampleData} = 80'h0;
    void'($urandom(45753));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, sts_pkg::OFS_CTRL, 32'h0, rd);
    `CHK("ctrl", 32'h0, rd)
    bus(1'b0, 8'h40, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, sts_pkg::OFS_GAP, 32'h3FF, rd);
    bus(1'b0, sts_pkg::OFS_GAP, 32'h0, rd);
    `CHK("gap", 32'h3FF, rd & 32'h3FF)
    $display("test registers done");
    gap = 2 + $urandom % 7;
    slp = 20 + $urandom % 21;
    bus(1'b1, sts_pkg::OFS_GAP, gap, rd);
    bus(1'b1, sts_pkg::OFS_THRESH, thresh_for(gap, slp), rd);
    bus(1'b1, sts_pkg::OFS_CTRL, 32'h3, rd);
    v = 16'h8000;
    repeat (1024) put_sample(v);
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, sts_pkg::OFS_CTRL, m ? 32'h1 : 32'h3, rd);
      repeat (2 * gap + 4) put_sample(v);
      {nTrig, nSamp} = 0;
      repeat (2 * gap)
      begin
        v = m ? v + 16'(slp) : v - 16'(slp);
        put_sample(v);
      end
      `CHK("trig count", 1, nTrig)
      `CHK("trig sample", gap - 1, trigAt)
    end
    bus(1'b0, sts_pkg::OFS_DIFF, 32'h0, rd);
    `CHK("diff", gap * slp, rd)
    bus(1'b0, sts_pkg::OFS_STATUS, 32'h0, rd);
    `CHK("trig pending", 1'b1, rd[0])
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, sts_pkg::OFS_MASK, 32'h1, rd);
    repeat (2) @(posedge clk_sys);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, sts_pkg::OFS_STATUS, 32'h1, rd);
    repeat (2) @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq)
    $display("test slope done");
    bus(1'b1, sts_pkg::OFS_CTRL, 32'h0, rd);
    i_src.pulse($urandom % 2, 60);
    repeat (80) @(posedge clk_sys);
    `CHK("disabled", 1'b0, acqRunning)
    for (int inv = 0; inv < 2; inv++)
    begin
      bus(1'b1, sts_pkg::OFS_CTRL, inv ? 32'h1C : 32'h4, rd);
      idleLevel <= inv[0];
      repeat (LOCK + 50) @(posedge clk_sys);
      i_src.pulse($urandom % 2, 40);
      repeat (60) @(posedge clk_sys);
      `CHK("short", 1'b0, acqRunning)
      i_src.pulse($urandom % 2, 54 + $urandom % 20);
      wait_run(1'b1, 100);
      `CHK("start", 1'b1, acqRunning)
      bus(1'b0, sts_pkg::OFS_STATE, 32'h0, rd);
      `CHK("state", 32'h00000001, rd)
      bus(1'b0, sts_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("begin pending", 1'b1, rd[1])
      i_src.pulse(2 + $urandom % 2, 60);
      wait_run(1'b0, 100);
      `CHK("stop in lockout", 1'b0, acqRunning)
      i_src.pulse($urandom % 2, 60);
      repeat (40) @(posedge clk_sys);
      `CHK("locked start", 1'b0, acqRunning)
      repeat (LOCK) @(posedge clk_sys);
      i_src.pulse($urandom % 2, 60);
      wait_run(1'b1, 100);
      `CHK("restart", 1'b1, acqRunning)
      i_src.pulse(2 + $urandom % 2, 60);
      wait_run(1'b0, 100);
      `CHK("stop", 1'b0, acqRunning)
      bus(1'b1, sts_pkg::OFS_STATUS, 32'h6, rd);
    end
    $display("test events done");
    stop_test();
  end
endmodule
`default_nettype wire
